// ### include/psf_pkg.sv
package psf_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL0  = 8'h00;
  localparam logic [7:0] ADDR_CTRL4  = 8'h04;
  localparam logic [7:0] ADDR_FEAT   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_MASK   = 8'h10;
  localparam logic [7:0] ADDR_LAST   = 8'h14;
  // Control bit positions
  localparam int POS_EM     = 2;
  localparam int POS_TS     = 3;
  localparam int POS_FXSR   = 9;
  localparam int POS_XMMEXC = 10;
  // Reset values
  localparam logic       RST_BIT  = 1'b0;
  localparam logic [7:0] RST_FEAT = 8'hFF;
  localparam logic [7:0] RST_MASK = 8'h00;
  // Address and privilege limits
  localparam logic [32:0] REAL_TOP  = 33'h0_0000_FFFF;
  localparam logic [1:0]  CPL_USER  = 2'h3;
  localparam logic [4:0]  ALIGN16   = 5'h10;
  // Exception kinds, one status bit each
  localparam int K_IO = 0;
  localparam int K_FE = 1;
  localparam int K_NA = 2;
  localparam int K_SS = 3;
  localparam int K_PR = 4;
  localparam int K_PG = 5;
  localparam int K_AL = 6;
  localparam int K_SF = 7;
  localparam int NKIND = 8;
  // Causes in priority order, lowest index wins
  localparam int C_IO   = 0;
  localparam int C_NA   = 1;
  localparam int C_FE   = 2;
  localparam int C_SS   = 3;
  localparam int C_PR   = 4;
  localparam int C_PG   = 5;
  localparam int C_AL   = 6;
  localparam int C_SFIO = 7;
  localparam int C_SF   = 8;
  localparam int NCAUSE = 9;
  // Vectors
  localparam logic [7:0] VEC_IO = 8'h06;
  localparam logic [7:0] VEC_NA = 8'h07;
  localparam logic [7:0] VEC_SS = 8'h0C;
  localparam logic [7:0] VEC_PR = 8'h0D;
  localparam logic [7:0] VEC_PG = 8'h0E;
  localparam logic [7:0] VEC_FE = 8'h10;
  localparam logic [7:0] VEC_AL = 8'h11;
  localparam logic [7:0] VEC_SF = 8'h13;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_REAL = 2'h0,
    MODE_V86  = 2'h1,
    MODE_PROT = 2'h2,
    MODE_LONG = 2'h3
  } psf_mode_type;

  // Cause index to exception kind
  function automatic int cause_kind(input int c);
    case (c)
      C_IO, C_SFIO: cause_kind = K_IO;
      C_NA:         cause_kind = K_NA;
      C_FE:         cause_kind = K_FE;
      C_SS:         cause_kind = K_SS;
      C_PR:         cause_kind = K_PR;
      C_PG:         cause_kind = K_PG;
      C_AL:         cause_kind = K_AL;
      default:      cause_kind = K_SF;
    endcase
  endfunction : cause_kind
endpackage : psf_pkg

// ### include/psf_req_if.sv
`timescale 1ns/1ns
// One issued instruction and its memory operand
interface psf_req_if;
  import psf_pkg::*;
  logic              valid;     // Issue pulse
  psf_mode_type      mode;      // Operating mode
  logic              lock;      // Bus-lock prefix seen
  logic [7:0]        feat_need; // Feature flags required
  logic              fpu_pend;  // Legacy FPU fault pending
  logic              simd_unm;  // Unmasked SIMD fault
  logic              mem;       // Has memory operand
  logic              ss_ref;    // Operand in stack segment
  logic              illegal;   // Segment check failed
  logic              noncanon;  // Non-canonical address
  logic              xlate_bad; // Translation failed
  logic [31:0]       ea;        // Effective address
  logic [4:0]        size;      // Operand bytes
  logic [1:0]        cpl;       // Privilege level
  logic              ac_en;     // Alignment checking on
  logic              grp_align; // Aligned-operand group
  logic              grp_conv;  // Packed-conversion group
  modport src (output valid, mode, lock, feat_need, fpu_pend, simd_unm, mem, ss_ref, illegal,
               noncanon, xlate_bad, ea, size, cpl, ac_en, grp_align, grp_conv);
  modport chk (input valid, mode, lock, feat_need, fpu_pend, simd_unm, mem, ss_ref, illegal,
               noncanon, xlate_bad, ea, size, cpl, ac_en, grp_align, grp_conv);
endinterface : psf_req_if

// ### design/psf_classify.sv
`timescale 1ns/1ns
// Raw fault causes for one request
module psf_classify
  import psf_pkg::*;
(
  psf_req_if.chk             req,
  input  wire logic [7:0]    feat_in,
  input  wire logic          em_in,
  input  wire logic          ts_in,
  input  wire logic          fxsr_in,
  input  wire logic          xmmexc_in,
  output logic [NCAUSE-1:0]  cause_out
);
  logic [32:0] last_byte; // Last operand byte address
  logic        in_prot;   // Protected or compatibility
  logic        in_long;   // 64-bit mode

  always_comb begin
    last_byte = {1'b0, req.ea} + {28'h0, req.size} - 33'h1;
    in_prot   = (req.mode == MODE_PROT);
    in_long   = (req.mode == MODE_LONG);
    cause_out = '0;
    cause_out[C_IO] = em_in | ~fxsr_in
                    | req.lock
                    | |(req.feat_need & ~feat_in);
    cause_out[C_NA] = ts_in;
    cause_out[C_FE] = req.fpu_pend;
    cause_out[C_SS] = req.mem & req.ss_ref &
                      ((in_prot & req.illegal)
                     | (in_long & req.noncanon));
    cause_out[C_PR] = req.mem &
                      ((req.grp_align & (req.ea[3:0] != 4'h0))
                     | (in_prot & ~req.ss_ref & req.illegal)
                     | (in_long & ~req.ss_ref & req.noncanon)
                     | (~req.mode[1] & (last_byte > REAL_TOP)));
    // Real mode has no paging
    cause_out[C_PG] = req.mem & req.xlate_bad & (req.mode != MODE_REAL);
    cause_out[C_AL] = req.mem & req.grp_conv & req.ac_en & (req.cpl == CPL_USER) &
                      (req.mode != MODE_REAL) &
                      ((req.ea[4:0] & (req.size - 5'h1)) != 5'h0);
    cause_out[C_SFIO] = req.simd_unm & ~xmmexc_in;
    cause_out[C_SF]   = req.simd_unm & xmmexc_in;
    if (!req.valid) begin
      cause_out = '0;
    end
  end
endmodule : psf_classify

// ### design/psf_prio.sv
`timescale 1ns/1ns
// Picks the winning cause and its vector
module psf_prio
  import psf_pkg::*;
(
  input  wire logic [NCAUSE-1:0] cause_in,
  output logic                   hit_out,
  output logic [NKIND-1:0]       kind_out,
  output logic [7:0]             vec_out,
  output logic                   code_out
);
  int win; // Winning cause index

  always_comb begin
    win = NCAUSE;
    for (int i = NCAUSE - 1; i >= 0; i--) begin
      if (cause_in[i]) begin
        win = i;
      end
    end
    hit_out  = (win != NCAUSE);
    kind_out = '0;
    if (hit_out) begin
      kind_out[cause_kind(win)] = 1'b1;
    end
    unique case (1'b1)
      kind_out[K_FE]: vec_out = VEC_FE;
      kind_out[K_NA]: vec_out = VEC_NA;
      kind_out[K_SS]: vec_out = VEC_SS;
      kind_out[K_PR]: vec_out = VEC_PR;
      kind_out[K_PG]: vec_out = VEC_PG;
      kind_out[K_AL]: vec_out = VEC_AL;
      kind_out[K_SF]: vec_out = VEC_SF;
      default:        vec_out = VEC_IO;
    endcase
    // Only these four push an error code
    code_out = kind_out[K_SS] | kind_out[K_PR] | kind_out[K_PG] | kind_out[K_AL];
  end
endmodule : psf_prio

// ### design/psf_fault_check.sv
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Fault qualification for packed SIMD instructions
module psf_fault_check
  import psf_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [31:0]      rdata_out,
  // Issued instruction
  input  wire logic        issue_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic        lock_in,
  input  wire logic [7:0]  feat_need_in,
  input  wire logic        fpu_pend_in,
  input  wire logic        simd_unm_in,
  input  wire logic        mem_in,
  input  wire logic        ss_ref_in,
  input  wire logic        illegal_in,
  input  wire logic        noncanon_in,
  input  wire logic        xlate_bad_in,
  input  wire logic [15:0] pf_code_in,
  input  wire logic [31:0] ea_in,
  input  wire logic [4:0]  size_in,
  input  wire logic [1:0]  cpl_in,
  input  wire logic        ac_en_in,
  input  wire logic        grp_align_in,
  input  wire logic        grp_conv_in,
  // Fault result
  output logic             fault_out,
  output logic [7:0]       fault_vec_out,
  output logic [NKIND-1:0] fault_kind_out,
  output logic             fault_has_code_out,
  output logic [15:0]      fault_code_out,
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // Request carrier

  psf_req_if req ();

  // Fan the plain ports into the carrier
  always_comb begin
    req.valid     = issue_in;
    req.mode      = psf_mode_type'(mode_in);
    req.lock      = lock_in;
    req.feat_need = feat_need_in;
    req.fpu_pend  = fpu_pend_in;
    req.simd_unm  = simd_unm_in;
    req.mem       = mem_in;
    req.ss_ref    = ss_ref_in;
    req.illegal   = illegal_in;
    req.noncanon  = noncanon_in;
    req.xlate_bad = xlate_bad_in;
    req.ea        = ea_in;
    req.size      = size_in;
    req.cpl       = cpl_in;
    req.ac_en     = ac_en_in;
    req.grp_align = grp_align_in;
    req.grp_conv  = grp_conv_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Control state

  logic             em_r;       // Emulation bit
  logic             em_nxt;
  logic             ts_r;       // Task-switched bit
  logic             ts_nxt;
  logic             fxsr_r;     // OS extended-save support
  logic             fxsr_nxt;
  logic             xmmexc_r;   // OS unmasked SIMD support
  logic             xmmexc_nxt;
  logic [7:0]       feat_r;     // Feature flags present
  logic [7:0]       feat_nxt;
  logic [NKIND-1:0] mask_r;     // Interrupt enables
  logic [NKIND-1:0] mask_nxt;

  // Decoded write strobes
  logic wr_ctrl0;
  logic wr_ctrl4;
  logic wr_feat;
  logic wr_status;
  logic wr_mask;

  // Address decode shared by writes
  always_comb begin
    wr_ctrl0  = wr_in & (addr_in == ADDR_CTRL0);
    wr_ctrl4  = wr_in & (addr_in == ADDR_CTRL4);
    wr_feat   = wr_in & (addr_in == ADDR_FEAT);
    wr_status = wr_in & (addr_in == ADDR_STATUS);
    wr_mask   = wr_in & (addr_in == ADDR_MASK);
  end

  // Next control values
  always_comb begin
    em_nxt     = em_r;
    ts_nxt     = ts_r;
    fxsr_nxt   = fxsr_r;
    xmmexc_nxt = xmmexc_r;
    feat_nxt   = feat_r;
    mask_nxt   = mask_r;
    if (wr_ctrl0) begin
      em_nxt = wdata_in[POS_EM];
      ts_nxt = wdata_in[POS_TS];
    end
    if (wr_ctrl4) begin
      fxsr_nxt   = wdata_in[POS_FXSR];
      xmmexc_nxt = wdata_in[POS_XMMEXC];
    end
    if (wr_feat) begin
      feat_nxt = wdata_in[7:0];
    end
    if (wr_mask) begin
      mask_nxt = wdata_in[NKIND-1:0];
    end
  end

  // Control registers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      em_r     <= RST_BIT;
      ts_r     <= RST_BIT;
      fxsr_r   <= RST_BIT;
      xmmexc_r <= RST_BIT;
      feat_r   <= RST_FEAT;
      mask_r   <= RST_MASK;
    end else begin
      em_r     <= em_nxt;
      ts_r     <= ts_nxt;
      fxsr_r   <= fxsr_nxt;
      xmmexc_r <= xmmexc_nxt;
      feat_r   <= feat_nxt;
      mask_r   <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Qualification

  logic [NCAUSE-1:0] cause;    // Raw causes this cycle
  logic              hit;      // Some fault raised
  logic [NKIND-1:0]  kind;     // Winning kind, one-hot
  logic [7:0]        vec;      // Winning vector
  logic              has_code; // Winner pushes error code

  // Per-mode checks
  psf_classify u_classify (
    .req       (req.chk),
    .feat_in   (feat_r),
    .em_in     (em_r),
    .ts_in     (ts_r),
    .fxsr_in   (fxsr_r),
    .xmmexc_in (xmmexc_r),
    .cause_out (cause)
  );

  // Earlier cause wins
  psf_prio u_prio (
    .cause_in (cause),
    .hit_out  (hit),
    .kind_out (kind),
    .vec_out  (vec),
    .code_out (has_code)
  );

  ////////////////////////////////////////////////////////////////////////
  // Fault result

  logic             fault_r;     // Result pulse
  logic             fault_nxt;
  logic [7:0]       vec_r;       // Vector held until next fault
  logic [7:0]       vec_nxt;
  logic [NKIND-1:0] kind_r;      // Kind held until next fault
  logic [NKIND-1:0] kind_nxt;
  logic             has_code_r;  // Error code present
  logic             has_code_nxt;
  logic [15:0]      code_r;      // Error code value
  logic [15:0]      code_nxt;

  // Capture the winner; only page faults carry a nonzero code
  always_comb begin
    fault_nxt    = hit;
    vec_nxt      = vec_r;
    kind_nxt     = kind_r;
    has_code_nxt = has_code_r;
    code_nxt     = code_r;
    if (hit) begin
      vec_nxt      = vec;
      kind_nxt     = kind;
      has_code_nxt = has_code;
      // Stack, GP and alignment faults report zero
      code_nxt     = kind[K_PG] ? pf_code_in : 16'h0000;
    end
  end

  // Result registers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fault_r    <= 1'b0;
      vec_r      <= 8'h00;
      kind_r     <= '0;
      has_code_r <= 1'b0;
      code_r     <= 16'h0000;
    end else begin
      fault_r    <= fault_nxt;
      vec_r      <= vec_nxt;
      kind_r     <= kind_nxt;
      has_code_r <= has_code_nxt;
      code_r     <= code_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky status and interrupt

  logic [NKIND-1:0] status_r;   // One bit per kind raised
  logic [NKIND-1:0] status_nxt;

  // Write one to clear; a new fault in the same cycle wins
  always_comb begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_r & ~wdata_in[NKIND-1:0];
    end
    if (hit) begin
      status_nxt = status_nxt | kind;
    end
  end

  // Status register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  logic [31:0] rdata_r;   // Read data, one cycle after strobe
  logic [31:0] rdata_nxt;

  // Unmapped addresses and idle cycles read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_in) begin
      unique case (addr_in)
        ADDR_CTRL0: begin
          rdata_nxt[POS_EM] = em_r;
          rdata_nxt[POS_TS] = ts_r;
        end
        ADDR_CTRL4: begin
          rdata_nxt[POS_FXSR]   = fxsr_r;
          rdata_nxt[POS_XMMEXC] = xmmexc_r;
        end
        ADDR_FEAT:   rdata_nxt[7:0]       = feat_r;
        ADDR_STATUS: rdata_nxt[NKIND-1:0] = status_r;
        ADDR_MASK:   rdata_nxt[NKIND-1:0] = mask_r;
        // Last fault: code, flag, vector
        ADDR_LAST:   rdata_nxt = {code_r, 7'h00, has_code_r, vec_r};
        default:     rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // All from flip-flops except the interrupt level
  always_comb begin
    rdata_out          = rdata_r;
    fault_out          = fault_r;
    fault_vec_out      = vec_r;
    fault_kind_out     = kind_r;
    fault_has_code_out = has_code_r;
    fault_code_out     = code_r;
    irq_out            = |(status_r & mask_r);
  end
endmodule : psf_fault_check

// ### verification/psf_fault_check_assertions.sv
`timescale 1ns/1ns
// Port-level checks of fault selection
module psf_fault_check_assertions
  import psf_pkg::*;
(
  input wire logic             clock_in,
  input wire logic             reset_in,
  input wire logic [7:0]       addr_in,
  input wire logic [31:0]      wdata_in,
  input wire logic             wr_in,
  input wire logic             rd_in,
  input wire logic [31:0]      rdata_out,
  input wire logic             issue_in,
  input wire logic [1:0]       mode_in,
  input wire logic             lock_in,
  input wire logic [7:0]       feat_need_in,
  input wire logic             fpu_pend_in,
  input wire logic             simd_unm_in,
  input wire logic             mem_in,
  input wire logic             ss_ref_in,
  input wire logic             grp_align_in,
  input wire logic [31:0]      ea_in,
  input wire logic             fault_out,
  input wire logic [7:0]       fault_vec_out,
  input wire logic [NKIND-1:0] fault_kind_out,
  input wire logic [15:0]      fault_code_out,
  input wire logic             irq_out
);
  logic       em_r, ts_r, fx_r, sf_r; // Shadow control bits
  logic [7:0] feat_r;                 // Shadow feature flags
  logic       ud_c;                   // Early invalid opcode due
  logic       clean_c;                // No early fault due
  ////////////////////////////////////////////////////////////////
  // Shadow the control registers, since they are not visible as ports
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      {em_r, ts_r, fx_r, sf_r, feat_r} <= {4'h0, 8'hFF};
    end else if (wr_in && addr_in == ADDR_CTRL0) begin
      {ts_r, em_r} <= wdata_in[3:2];
    end else if (wr_in && addr_in == ADDR_CTRL4) begin
      {sf_r, fx_r} <= wdata_in[10:9];
    end else if (wr_in && addr_in == ADDR_FEAT) begin
      feat_r <= wdata_in[7:0];
    end
  end
  assign ud_c    = lock_in | em_r | ~fx_r | (|(feat_need_in & ~feat_r));
  assign clean_c = ~ud_c & ~ts_r & ~fpu_pend_in;
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  property p_ud; issue_in && ud_c |=> fault_out && fault_vec_out == VEC_IO; endproperty
  a_ud: assert property (p_ud) else $error("invalid opcode missing");
  property p_nm; issue_in && !ud_c && ts_r |=> fault_out && fault_vec_out == VEC_NA; endproperty
  a_nm: assert property (p_nm) else $error("device not available missing");
  property p_mf; issue_in && !ud_c && !ts_r && fpu_pend_in |=> fault_out && fault_vec_out == VEC_FE; endproperty
  a_mf: assert property (p_mf) else $error("fp error missing");
  property p_simd;
    issue_in && clean_c && !mem_in && simd_unm_in |=> fault_out && fault_vec_out == (sf_r ? VEC_SF : VEC_IO);
  endproperty
  a_simd: assert property (p_simd) else $error("simd fault wrong");
  property p_align;
    issue_in && clean_c && mem_in && grp_align_in && ea_in[3:0] != 4'h0 && !ss_ref_in |=> fault_vec_out == VEC_PR;
  endproperty
  a_align: assert property (p_align) else $error("misaligned operand passed");
  property p_real_pf; issue_in && mode_in == 2'h0 |=> !(fault_out && fault_kind_out[K_PG]); endproperty
  a_real_pf: assert property (p_real_pf) else $error("page fault in real mode");
  property p_code; fault_out && !fault_kind_out[K_PG] |-> fault_code_out == 16'h0000; endproperty
  a_code: assert property (p_code) else $error("nonzero error code");
  property p_pulse; fault_out |-> $past(issue_in) ##1 !fault_out || $past(issue_in); endproperty
  a_pulse: assert property (p_pulse) else $error("fault without issue");
  property p_rd; !$past(rd_in) |-> rdata_out == 32'h0000_0000; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  c_lock: cover property (issue_in && lock_in);
  c_xm: cover property (fault_out && fault_vec_out == VEC_SF);
  c_irq: cover property ($rose(irq_out));
endmodule : psf_fault_check_assertions

bind psf_fault_check psf_fault_check_assertions u_chk (
  .clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .issue_in(issue_in), .mode_in(mode_in), .lock_in(lock_in),
  .feat_need_in(feat_need_in), .fpu_pend_in(fpu_pend_in), .simd_unm_in(simd_unm_in), .mem_in(mem_in),
  .ss_ref_in(ss_ref_in), .grp_align_in(grp_align_in), .ea_in(ea_in), .fault_out(fault_out),
  .fault_vec_out(fault_vec_out), .fault_kind_out(fault_kind_out), .fault_code_out(fault_code_out),
  .irq_out(irq_out));

// ### verification/psf_fault_check_bench.sv
`timescale 1ns/1ns
// Self-checking bench for the fault qualifier
module psf_fault_check_bench
  import psf_pkg::*;
;
  logic clock_in = 0, reset_in = 1, wr_in = 0, rd_in = 0, issue_in = 0;  // Clock, reset, strobes
  logic lock_in = 0, fpu_pend_in = 0, simd_unm_in = 0, mem_in = 0, ss_ref_in = 0, illegal_in = 0;
  logic noncanon_in = 0, xlate_bad_in = 0, ac_en_in = 0, grp_align_in = 0, grp_conv_in = 0;
  logic [1:0]  mode_in = 0, cpl_in = 0;                 // Mode and privilege
  logic [7:0]  addr_in = 0, feat_need_in = 0;           // Bus address, needed flags
  logic [31:0] wdata_in = 0, ea_in = 0;                 // Write data, operand address
  logic [15:0] pf_code_in = 0;                          // Page fault code
  logic [4:0]  size_in = 5'h08;                         // Operand bytes
  logic [31:0] rdata_out;                               // Read data
  logic        fault_out, fault_has_code_out, irq_out;  // Fault pulse, code flag, interrupt
  logic [7:0]  fault_vec_out, fault_kind_out;           // Vector and one-hot kind
  logic [15:0] fault_code_out;                          // Error code
  logic        em = 0, ts = 0, fx = 0, sf = 0;          // Expected control bits
  logic [7:0]  feat = 8'hFF, msk = 8'h00, exp_st = 0;   // Expected flags, mask, status
  logic [7:0]  vl [8] = '{VEC_IO, VEC_FE, VEC_NA, VEC_SS, VEC_PR, VEC_PG, VEC_AL, VEC_SF}; // Vector per kind bit
  int          n_fail = 0, checked = 0;                 // Counters

  psf_fault_check u_dut (
    .clock_in(clock_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .issue_in(issue_in), .mode_in(mode_in), .lock_in(lock_in),
    .feat_need_in(feat_need_in), .fpu_pend_in(fpu_pend_in), .simd_unm_in(simd_unm_in), .mem_in(mem_in),
    .ss_ref_in(ss_ref_in), .illegal_in(illegal_in), .noncanon_in(noncanon_in), .xlate_bad_in(xlate_bad_in),
    .pf_code_in(pf_code_in), .ea_in(ea_in), .size_in(size_in), .cpl_in(cpl_in), .ac_en_in(ac_en_in),
    .grp_align_in(grp_align_in), .grp_conv_in(grp_conv_in), .fault_out(fault_out),
    .fault_vec_out(fault_vec_out), .fault_kind_out(fault_kind_out), .fault_has_code_out(fault_has_code_out),
    .fault_code_out(fault_code_out), .irq_out(irq_out));

  ////////////////////////////////////////////////////////////////
  // Clock
  always #5 clock_in = ~clock_in;

  // Compare and count; X on the design side never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Expected vector by the chosen priority, 0 when no fault
  function automatic logic [7:0] pred();
    logic [32:0] top;
    logic        bad;
    top = {1'b0, ea_in} + 33'(size_in) - 33'h1;
    bad = (mode_in == 2'h2 && illegal_in) || (mode_in == 2'h3 && noncanon_in);
    if (lock_in || em || !fx || (feat_need_in & ~feat) != 8'h00) return VEC_IO;
    if (ts) return VEC_NA;
    if (fpu_pend_in) return VEC_FE;
    if (mem_in && bad && ss_ref_in) return VEC_SS;
    if (mem_in && ((grp_align_in && ea_in[3:0] != 4'h0) || (bad && !ss_ref_in) ||
        (mode_in < 2'h2 && top > REAL_TOP))) return VEC_PR;
    if (mem_in && xlate_bad_in && mode_in != 2'h0) return VEC_PG;
    if (mem_in && grp_conv_in && ac_en_in && cpl_in == CPL_USER && mode_in != 2'h0 &&
        (ea_in[3:0] & (size_in[3:0] - 4'h1)) != 4'h0) return VEC_AL;
    if (simd_unm_in) return sf ? VEC_SF : VEC_IO;
    return 8'h00;
  endfunction : pred

  // One-hot kind of a vector
  function automatic logic [7:0] kind_of(input logic [7:0] v);
    logic [7:0] k;
    k = 8'h00;
    for (int i = 0; i < 8; i++) k[i] = (vl[i] == v);
    return k;
  endfunction : kind_of

  // Register write; the expected copy follows it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    if (a == ADDR_CTRL0) {ts, em} = d[3:2];
    if (a == ADDR_CTRL4) {sf, fx} = d[10:9];
    if (a == ADDR_FEAT) feat = d[7:0];
    if (a == ADDR_MASK) msk = d[7:0];
    if (a == ADDR_STATUS) exp_st = exp_st & ~d[7:0];
  endtask : wr

  // Register read, data checked in the following cycle only
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 chk("read data", e, rdata_out);
  endtask : rd

  // Issue the request already on the inputs and check the answer a cycle later
  task automatic go();
    logic [7:0] v;
    issue_in <= 1'b1;
    @(posedge clock_in);
    issue_in <= 1'b0;
    #1 v = pred();
    chk("fault pulse", v != 8'h00, fault_out);
    if (v != 8'h00) begin
      chk("vector", v, fault_vec_out);
      chk("kind", kind_of(v), fault_kind_out);
      chk("has code", v inside {VEC_SS, VEC_PR, VEC_PG, VEC_AL}, fault_has_code_out);
      chk("code", v == VEC_PG ? pf_code_in : 16'h0000, fault_code_out);
      exp_st = exp_st | kind_of(v);
    end
  endtask : go

  // Quiet request defaults
  task automatic clr();
    {lock_in, fpu_pend_in, simd_unm_in, mem_in, ss_ref_in, illegal_in, noncanon_in} <= 7'h00;
    {xlate_bad_in, ac_en_in, grp_align_in, grp_conv_in, feat_need_in, ea_in} <= 44'h0;
    size_in <= 5'h08;
    cpl_in  <= CPL_USER;
  endtask : clr

  // Random request, biased so each cause shows up often
  task automatic rnd();
    {mode_in, cpl_in, size_in} <= {4'($urandom), $urandom % 2 ? 5'h10 : 5'h08};
    {lock_in, fpu_pend_in, simd_unm_in} <= {$urandom % 12 == 0, $urandom % 10 == 0, $urandom % 3 == 0};
    {mem_in, ss_ref_in, illegal_in, noncanon_in} <= {$urandom % 4 != 0, 3'($urandom)};
    {xlate_bad_in, ac_en_in, grp_align_in, grp_conv_in} <= 4'($urandom);
    feat_need_in <= $urandom % 6 == 0 ? 8'($urandom) : 8'h01;
    ea_in      <= $urandom % 2 ? 32'h0000_FFE0 + ($urandom % 32) : $urandom;
    pf_code_in <= 16'($urandom);
  endtask : rnd

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////
  // Watchdog: run needs about 1050 cycles, allow about nineteen times that
  initial begin
    #200000;
    n_fail++;
    test_done();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hF354FEB1));
    repeat (3) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(ADDR_CTRL0, 32'h0);
    rd(ADDR_CTRL4, 32'h0);
    rd(ADDR_FEAT, 32'h0000_00FF);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_LAST, 32'h0);
    rd(8'h18, 32'h0);
    $display("test reset values done");
    @(posedge clock_in);
    clr();
    go();
    chk("irq masked", 1'b0, irq_out);
    wr(ADDR_MASK, 32'h0000_00FF);
    #1 chk("irq", 1'b1, irq_out);
    rd(ADDR_STATUS, 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0001);
    #1 chk("irq cleared", 1'b0, irq_out);
    $display("test interrupt done");
    for (int x = 0; x < 2; x++) begin
      wr(ADDR_CTRL4, {21'h0, x[0], 1'b1, 9'h0});
      for (int m = 0; m < 4; m++) begin
        for (int c = 0; c < 8; c++) begin
          @(posedge clock_in);
          clr();
          mode_in <= 2'(m);
          mem_in  <= c > 2;
          case (c)
            0: lock_in <= 1'b1;
            1: fpu_pend_in <= 1'b1;
            2: simd_unm_in <= 1'b1;
            3: {xlate_bad_in, pf_code_in} <= {1'b1, 16'hA5C3};
            4: {ss_ref_in, illegal_in, noncanon_in} <= 3'h7;
            5: ea_in <= 32'h0000_FFF9;
            6: {grp_conv_in, ac_en_in, ea_in} <= {2'h3, 32'h0000_0002};
            default: {grp_align_in, ea_in} <= {1'b1, 32'h0000_0008};
          endcase
          go();
        end
      end
    end
    rd(ADDR_LAST, {16'h0, 7'h0, 1'b1, VEC_PR});
    $display("test mode table done");
    for (int n = 0; n < 400; n++) begin
      if (n % 25 == 0) begin
        wr(ADDR_CTRL0, {28'h0, $urandom % 6 == 0, $urandom % 8 == 0, 2'h0});
        wr(ADDR_CTRL4, {21'h0, 1'($urandom), $urandom % 8 != 0, 9'h0});
        wr(ADDR_FEAT, {24'h0, $urandom % 2 ? 8'hFF : 8'($urandom)});
      end
      @(posedge clock_in);
      rnd();
      go();
    end
    rd(ADDR_STATUS, {24'h0, exp_st});
    chk("irq level", |(exp_st & msk), irq_out);
    $display("test random issue done");
    test_done();
  end
endmodule : psf_fault_check_bench
